// *** gp_timer.sv ***
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////

module gp_timer
#(
  parameter int addr_w = 10
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [addr_w-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // count clock tick from the clock manager
  input  wire logic              count_tick,
  // slow clock pin
  input  wire logic              slow_clk,
  // capture trigger and outputs
  input  wire logic              capture_in,
  output logic                   trigger_out,
  output logic                   gp_out,
  output logic                   irq
);

  //////////////////////////////////////////////////////////////////////////
  // registers

  logic [timer_pkg::ctrl_w-1:0] ctrl;
  logic [31:0]                  count;
  logic [31:0]                  load_value;
  logic [31:0]                  compare_value;
  logic [31:0]                  capture_value;
  logic [2:0]                   status;
  logic [2:0]                   irq_mask;
  logic [31:0]                  slow_count;
  logic [8:0]                   pre_cnt;
  logic                         stopped;

  timer_pkg::bus_state_e        bus_state;

  logic       start_en;
  logic       reload_en;
  logic       cmp_en;
  logic       cap_en;
  logic       pwm_en;
  logic [3:0] pre_sel;

  assign start_en  = ctrl[timer_pkg::ctrl_start_bit];
  assign reload_en = ctrl[timer_pkg::ctrl_reload_bit];
  assign cmp_en    = ctrl[timer_pkg::ctrl_cmp_en_bit];
  assign cap_en    = ctrl[timer_pkg::ctrl_cap_en_bit];
  assign pwm_en    = ctrl[timer_pkg::ctrl_pwm_bit];
  assign pre_sel   = ctrl[timer_pkg::ctrl_pre_lsb +: timer_pkg::ctrl_pre_w];

  //////////////////////////////////////////////////////////////////////////
  // slow counter

  slow_counter u_slow
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .slow_clk   (slow_clk),
    .slow_count (slow_count)
  );

  //////////////////////////////////////////////////////////////////////////
  // capture pin sampler, rising edge detect on agreed stages

  logic cap_a;
  logic cap_b;
  logic cap_c;
  logic cap_level;
  logic cap_rise;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cap_a <= 1'b0;
      cap_b <= 1'b0;
      cap_c <= 1'b0;
      cap_level <= 1'b0;
    end
    else
    begin
      cap_a <= capture_in;
      cap_b <= cap_a;
      cap_c <= cap_b;
      if (cap_b == cap_c)
        cap_level <= cap_c;
    end
  end

  assign cap_rise = (cap_b == cap_c) && cap_c && !cap_level;

  //////////////////////////////////////////////////////////////////////////
  // bus decode

  logic       setup;
  logic       wr_take;
  logic       word_sel;
  logic       valid_sz;
  logic       known;
  logic [31:0] wmask;
  logic [11:0] byte_addr;

  assign byte_addr = {{(12 - addr_w){1'b0}}, paddr};
  assign setup     = psel && !penable && (bus_state == timer_pkg::bus_idle);
  // only full words or aligned halves are accepted for writes
  assign valid_sz  = (pstrb == 4'hf) || (pstrb == 4'h3) || (pstrb == 4'hc);
  assign word_sel  = (byte_addr[1:0] == 2'b00);
  assign wmask     = {{16{pstrb[3]}}, {16{pstrb[0]}}};
  assign known     = (byte_addr == timer_pkg::off_ctrl) ||
                     (byte_addr == timer_pkg::off_count) ||
                     (byte_addr == timer_pkg::off_load) ||
                     (byte_addr == timer_pkg::off_compare) ||
                     (byte_addr == timer_pkg::off_capture) ||
                     (byte_addr == timer_pkg::off_status) ||
                     (byte_addr == timer_pkg::off_irq_mask) ||
                     (byte_addr == timer_pkg::off_slow_cnt);

  // one wait state: setup, access, then pready in the done state
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      bus_state <= timer_pkg::bus_idle;
    else
    begin
      case (bus_state)
        timer_pkg::bus_idle:
          if (setup)
            bus_state <= timer_pkg::bus_access;
        timer_pkg::bus_access:
          bus_state <= timer_pkg::bus_done;
        timer_pkg::bus_done:
          bus_state <= timer_pkg::bus_idle;
        default:
          bus_state <= timer_pkg::bus_idle;
      endcase
    end
  end

  // write commits in the access cycle just before pready is raised
  assign wr_take = (bus_state == timer_pkg::bus_access) && psel && penable && pwrite &&
                   word_sel && valid_sz;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (bus_state == timer_pkg::bus_access)
    begin
      pready  <= 1'b1;
      // slow counter writes end quietly; bad size or hole is an error
      pslverr <= !known || !word_sel || (pwrite && !valid_sz);
      prdata  <= 32'h0000_0000;
      if (!pwrite)
      begin
        case (byte_addr)
          timer_pkg::off_ctrl:     prdata <= {20'h00000, ctrl};
          timer_pkg::off_count:    prdata <= count;
          timer_pkg::off_load:     prdata <= load_value;
          timer_pkg::off_compare:  prdata <= compare_value;
          timer_pkg::off_capture:  prdata <= capture_value;
          timer_pkg::off_status:   prdata <= {29'h0000_0000, status};
          timer_pkg::off_irq_mask: prdata <= {29'h0000_0000, irq_mask};
          timer_pkg::off_slow_cnt: prdata <= slow_count;
          default:                 prdata <= 32'h0000_0000;
        endcase
      end
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      ctrl <= timer_pkg::ctrl_reset;
    else if (wr_take && byte_addr == timer_pkg::off_ctrl)
      ctrl <= (ctrl & ~wmask[11:0]) | (pwdata[11:0] & wmask[11:0]);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      load_value    <= timer_pkg::load_reset;
      compare_value <= timer_pkg::compare_reset;
      irq_mask      <= timer_pkg::mask_reset;
    end
    else if (wr_take)
    begin
      if (byte_addr == timer_pkg::off_load)
        load_value <= (load_value & ~wmask) | (pwdata & wmask);
      if (byte_addr == timer_pkg::off_compare)
        compare_value <= (compare_value & ~wmask) | (pwdata & wmask);
      if (byte_addr == timer_pkg::off_irq_mask)
        irq_mask <= (irq_mask & ~wmask[2:0]) | (pwdata[2:0] & wmask[2:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // prescaler and counter

  logic [8:0] pre_limit;
  logic       pre_hit;
  logic       step;
  logic       ovf;

  // exponents above 8 saturate at 9 (limit 0x1ff, divide by 512)
  assign pre_limit = (pre_sel > timer_pkg::pre_max) ? 9'h1ff :
                     9'((10'h001 << pre_sel) - 10'h001);
  assign pre_hit   = (pre_cnt >= pre_limit);
  // count_tick is the selected count clock as an enable from outside
  assign step      = start_en && !stopped && count_tick && pre_hit;
  assign ovf       = step && (count == 32'hffff_ffff);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      pre_cnt <= 9'h000;
    else if (!start_en)
      pre_cnt <= 9'h000;
    else if (count_tick)
      pre_cnt <= pre_hit ? 9'h000 : pre_cnt + 9'h001;
  end

  // load value of 0xffffffe0 at 32768 Hz with n=0 gives a 32-tick period, about 0.98 ms
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      count   <= timer_pkg::count_reset;
      stopped <= 1'b0;
    end
    else if (wr_take && byte_addr == timer_pkg::off_count)
    begin
      count   <= (count & ~wmask) | (pwdata & wmask);
      stopped <= 1'b0;
    end
    else if (ovf)
    begin
      if (reload_en)
        count <= load_value;
      else
      begin
        count   <= 32'h0000_0000;
        stopped <= 1'b1;
      end
    end
    else if (step)
      count <= count + 32'h0000_0001;
  end

  //////////////////////////////////////////////////////////////////////////
  // compare, capture and status

  logic cmp_hit;

  assign cmp_hit = cmp_en && step && (count + 32'h0000_0001 == compare_value);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      capture_value <= 32'h0000_0000;
    else if (cap_en && cap_rise)
      capture_value <= count;
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      status <= 3'h0;
    else
    begin
      status[timer_pkg::st_ovf_bit] <= ovf ||
        (status[timer_pkg::st_ovf_bit] &&
         !(wr_take && byte_addr == timer_pkg::off_status && pwdata[timer_pkg::st_ovf_bit]));
      status[timer_pkg::st_cmp_bit] <= cmp_hit ||
        (status[timer_pkg::st_cmp_bit] &&
         !(wr_take && byte_addr == timer_pkg::off_status && pwdata[timer_pkg::st_cmp_bit]));
      status[timer_pkg::st_cap_bit] <= (cap_en && cap_rise) ||
        (status[timer_pkg::st_cap_bit] &&
         !(wr_take && byte_addr == timer_pkg::off_status && pwdata[timer_pkg::st_cap_bit]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      irq         <= 1'b0;
      gp_out      <= 1'b0;
      trigger_out <= 1'b0;
    end
    else
    begin
      irq    <= |(status & irq_mask);
      gp_out <= ctrl[timer_pkg::ctrl_gpo_bit];
      // pwm: set on overflow, cleared on compare, overflow wins; else pulse on either
      if (pwm_en)
      begin
        if (ovf)
          trigger_out <= 1'b1;
        else if (cmp_hit)
          trigger_out <= 1'b0;
      end
      else
        trigger_out <= ovf || cmp_hit;
    end
  end

endmodule : gp_timer

// *** timer_pkg.sv ***
package timer_pkg;

  // register byte offsets, general-purpose timer
  localparam logic [11:0] off_ctrl      = 12'h000;
  localparam logic [11:0] off_count     = 12'h004;
  localparam logic [11:0] off_load      = 12'h008;
  localparam logic [11:0] off_compare   = 12'h00c;
  localparam logic [11:0] off_capture   = 12'h010;
  localparam logic [11:0] off_status    = 12'h014;
  localparam logic [11:0] off_irq_mask  = 12'h018;
  // synchronized slow counter, read only
  localparam logic [11:0] off_slow_cnt  = 12'h040;

  // control register field positions
  localparam int ctrl_start_bit   = 0;
  localparam int ctrl_reload_bit  = 1;
  localparam int ctrl_cmp_en_bit  = 2;
  localparam int ctrl_cap_en_bit  = 3;
  localparam int ctrl_pwm_bit     = 4;
  localparam int ctrl_gpo_bit     = 5;
  localparam int ctrl_pre_lsb     = 8;
  localparam int ctrl_pre_w       = 4;
  localparam int ctrl_w           = 12;

  // status bit positions
  localparam int st_ovf_bit = 0;
  localparam int st_cmp_bit = 1;
  localparam int st_cap_bit = 2;

  // reset values
  localparam logic [11:0] ctrl_reset    = 12'h000;
  localparam logic [31:0] count_reset   = 32'h0000_0000;
  localparam logic [31:0] load_reset    = 32'h0000_0000;
  localparam logic [31:0] compare_reset = 32'hffff_ffff;
  localparam logic [2:0]  mask_reset    = 3'h0;
  localparam logic [31:0] slow_reset    = 32'h0000_0000;

  // prescaler exponent limit
  localparam logic [3:0] pre_max = 4'h8;

  // bus access states
  typedef enum logic [2:0] {
    bus_idle   = 3'b001,
    bus_access = 3'b010,
    bus_done   = 3'b100
  } bus_state_e;

endpackage : timer_pkg

// *** slow_counter.sv ***
`timescale 1ns/10ps

// counts falling edges of the slow clock seen through a three-stage sampler
module slow_counter
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // slow clock pin
  input  wire logic        slow_clk,
  // counter value
  output logic [31:0]      slow_count
);

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic level;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      sync_a <= slow_clk;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // filtered level changes only when the last two stages agree
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      level <= 1'b0;
    else if (sync_b == sync_c)
      level <= sync_c;
  end

  // free-running, wraps to zero past the top; no start needed
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      slow_count <= timer_pkg::slow_reset;
    else if (level && (sync_b == sync_c) && !sync_c)
      slow_count <= slow_count + 32'h0000_0001;
  end

endmodule : slow_counter

// *** gp_timer_sva.sv ***
`timescale 1ns/10ps

module gp_timer_sva
#(
  parameter int addr_w = 10
)
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [addr_w-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  // timer outputs
  input wire logic              trigger_out,
  input wire logic              gp_out,
  input wire logic              irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ack;
    psel && penable && pready;
  endsequence

  property p_ack_latency;
    s_setup |-> ##[1:4] pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  property p_narrow_refused;
    s_ack ##0 (pwrite && !(pstrb inside {4'hf, 4'h3, 4'hc})) |-> pslverr;
  endproperty
  property p_unaligned;
    s_ack ##0 (paddr[1:0] != 2'b00) |-> pslverr;
  endproperty
  property p_slow_write_quiet;
    s_ack ##0 (pwrite && pstrb == 4'hf && paddr == addr_w'(timer_pkg::off_slow_cnt)) |-> !pslverr;
  endproperty
  property p_word_accepted;
    s_ack ##0 (pstrb inside {4'hf, 4'h0} && paddr[1:0] == 2'b00 && paddr <= 'h18) |-> !pslverr;
  endproperty
  // gp_out is registered from ctrl, so it shows the written bit one cycle after the ack
  property p_gp_follows;
    s_ack ##0 (pwrite && !pslverr && paddr == '0 && pstrb[0]) |->
      ##1 (gp_out == $past(pwdata[5]));
  endproperty
  property p_reset_quiet;
    $rose(reset_n) |-> (!pready && !irq && !gp_out && !trigger_out) [*2];
  endproperty

  a_ack_latency:      assert property (p_ack_latency) else $error("no ready after setup");
  a_ready_pulse:      assert property (p_ready_pulse) else $error("ready held too long");
  a_ready_in_access:  assert property (p_ready_in_access) else $error("stray ready");
  a_narrow_refused:   assert property (p_narrow_refused) else $error("byte write taken");
  a_unaligned:        assert property (p_unaligned) else $error("unaligned taken");
  a_slow_write_quiet: assert property (p_slow_write_quiet) else $error("slow write erred");
  a_word_accepted:    assert property (p_word_accepted) else $error("word access erred");
  a_gp_follows:       assert property (p_gp_follows) else $error("gp output wrong");
  a_reset_quiet:      assert property (p_reset_quiet) else $error("outputs busy at reset");
endmodule : gp_timer_sva

bind gp_timer gp_timer_sva #(.addr_w(addr_w)) u_gp_timer_sva (.core_clk(core_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .trigger_out(trigger_out), .gp_out(gp_out), .irq(irq));

// *** clock_manager_model.sv ***
`timescale 1ns/10ps

module clock_manager_model
#(
  parameter int tick_every = 2,
  parameter int slow_half  = 8
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // capture request from the bench
  input  wire logic fire,
  // toward the timer
  output logic      count_tick,
  output logic      slow_clk,
  output logic      capture_in
);
  int tick_cnt;
  int slow_cnt;

  initial
  begin
    tick_cnt = 0;
    slow_cnt = 0;
    count_tick = 1'b0;
    slow_clk = 1'b0;
    capture_in = 1'b0;
  end

  // one pulse per count clock period, chosen outside the timer
  always @(posedge core_clk)
  begin
    tick_cnt <= (!reset_n || tick_cnt >= tick_every - 1) ? 0 : tick_cnt + 1;
    count_tick <= reset_n && tick_cnt == 0;
  end

  // slow clock runs free from power-on, never paused
  always @(posedge core_clk)
  begin
    slow_cnt <= (slow_cnt == slow_half - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == slow_half - 1)
      slow_clk <= ~slow_clk;
  end

  // trigger registered so it moves only just after an edge
  always @(posedge core_clk)
    capture_in <= fire;
endmodule : clock_manager_model

// *** gp_timer_and_sync_counter_test.sv ***
`timescale 1ns/10ps

`define chk(nm, ex, got) \
  begin samples_checked++; if ((got) !== (ex)) \
  begin fails++; $display("BAD %s exp %h got %h", nm, ex, got); end end

module gp_timer_and_sync_counter_test;
  logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err, fire;
  logic        count_tick, slow_clk, capture_in, trigger_out, gp_out, irq;
  logic [9:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd, a0, ex;
  int          fails, samples_checked;

  gp_timer u_gp_timer (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
    .slow_clk(slow_clk), .capture_in(capture_in), .trigger_out(trigger_out),
    .gp_out(gp_out), .irq(irq));
  clock_manager_model u_clock_manager_model (.core_clk(core_clk), .reset_n(reset_n),
    .fire(fire), .count_tick(count_tick), .slow_clk(slow_clk), .capture_in(capture_in));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // request held until pready is seen at an edge; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a[9:0];
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `chk(nm, e, rd)
  endtask : rdc

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fails++;
    close_out();
  end

  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    fire = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rdc("ctrl", timer_pkg::off_ctrl, 32'(timer_pkg::ctrl_reset));
    rdc("count", timer_pkg::off_count, timer_pkg::count_reset);
    rdc("load", timer_pkg::off_load, timer_pkg::load_reset);
    rdc("compare", timer_pkg::off_compare, timer_pkg::compare_reset);
    rdc("status", timer_pkg::off_status, 32'h0);
    rdc("mask", timer_pkg::off_irq_mask, 32'(timer_pkg::mask_reset));
    apb(1'b1, timer_pkg::off_load, 32'h1234_5678, 4'h1);
    `chk("byte err", 1'b1, err)
    rdc("load kept", timer_pkg::off_load, timer_pkg::load_reset);
    apb(1'b1, timer_pkg::off_load, 32'hbeef_cafe, 4'h3);
    rdc("half load", timer_pkg::off_load, 32'h0000_cafe);
    apb(1'b0, 12'h002, 32'h0, 4'h0);
    `chk("unaligned err", 1'b1, err)
    apb(1'b0, 12'h080, 32'h0, 4'h0);
    `chk("unmapped err", 1'b1, err)
    wr(timer_pkg::off_ctrl, 32'h20);
    repeat (2) @(posedge core_clk);
    `chk("gp out", 1'b1, gp_out)
    // count rate halves per prescale step; ticks come every second cycle
    for (int n = 0; n <= 8; n++)
    begin
      wr(timer_pkg::off_count, 32'h0);
      wr(timer_pkg::off_ctrl, (n << 8) | 1);
      repeat (512) @(posedge core_clk);
      wr(timer_pkg::off_ctrl, 32'h0);
      apb(1'b0, timer_pkg::off_count, 32'h0, 4'h0);
      ex = 32'd258 >> n;
      `chk("prescale", 1'b1, rd + 2 >= ex && rd <= ex + 2)
    end
    rdc("held", timer_pkg::off_count, rd);
    wr(timer_pkg::off_irq_mask, 32'h7);
    wr(timer_pkg::off_count, 32'hffff_fff0);
    wr(timer_pkg::off_ctrl, 32'h1);
    repeat (64) @(posedge core_clk);
    rdc("stopped", timer_pkg::off_count, 32'h0);
    rdc("ovf", timer_pkg::off_status, 32'h1);
    `chk("irq on", 1'b1, irq)
    wr(timer_pkg::off_ctrl, 32'h0);
    wr(timer_pkg::off_status, 32'h7);
    repeat (2) @(posedge core_clk);
    `chk("irq off", 1'b0, irq)
    wr(timer_pkg::off_load, 32'h1000);
    wr(timer_pkg::off_count, 32'hffff_fff0);
    wr(timer_pkg::off_ctrl, 32'h3);
    repeat (64) @(posedge core_clk);
    wr(timer_pkg::off_ctrl, 32'h0);
    apb(1'b0, timer_pkg::off_count, 32'h0, 4'h0);
    `chk("reload", 1'b1, rd >= 32'h1000 && rd < 32'h1100)
    // pwm level: overflow drives the trigger high, no compare to drop it
    wr(timer_pkg::off_count, 32'hffff_fff0);
    wr(timer_pkg::off_ctrl, 32'h13);
    repeat (64) @(posedge core_clk);
    `chk("pwm high", 1'b1, trigger_out)
    wr(timer_pkg::off_ctrl, 32'h0);
    repeat (2) @(posedge core_clk);
    `chk("pwm low", 1'b0, trigger_out)
    wr(timer_pkg::off_status, 32'h7);
    wr(timer_pkg::off_count, 32'h0);
    wr(timer_pkg::off_compare, 32'h40);
    wr(timer_pkg::off_ctrl, 32'h5);
    apb(1'b0, timer_pkg::off_count, 32'h0, 4'h0);
    a0 = rd;
    apb(1'b0, timer_pkg::off_count, 32'h0, 4'h0);
    `chk("on the fly", 1'b1, rd > a0)
    repeat (200) @(posedge core_clk);
    rdc("cmp", timer_pkg::off_status, 32'h2);
    wr(timer_pkg::off_status, 32'h7);
    wr(timer_pkg::off_count, 32'h0);
    wr(timer_pkg::off_ctrl, 32'h9);
    repeat (100) @(posedge core_clk);
    fire <= 1'b1;
    repeat (8) @(posedge core_clk);
    fire <= 1'b0;
    repeat (8) @(posedge core_clk);
    rdc("cap", timer_pkg::off_status, 32'h4);
    apb(1'b0, timer_pkg::off_capture, 32'h0, 4'h0);
    `chk("cap value", 1'b1, rd > 0 && rd < 32'h100)
    apb(1'b0, timer_pkg::off_slow_cnt, 32'h0, 4'h0);
    a0 = rd;
    `chk("slow runs", 1'b1, a0 != 0)
    wr(timer_pkg::off_slow_cnt, 32'h0);
    `chk("slow write", 1'b0, err)
    repeat (160) @(posedge core_clk);
    apb(1'b0, timer_pkg::off_slow_cnt, 32'h0, 4'h0);
    `chk("slow rate", 1'b1, rd - a0 >= 8 && rd - a0 <= 13)
    close_out();
  end
endmodule : gp_timer_and_sync_counter_test
